// file: hdl/pcf_clock_control.sv
// clock start-up, multiplier enable and fail-safe control
//
// What this block does
// - multiplier accepts 4 to 16 MHz references
// - enabled multiplier gives four times input
// - config enable forces on, else software, except for external primary
// - per-source restrictions on both enables
// - two-speed runs internal during start-up count
// - else crystal start waits 1024 oscillations
// - return to primary when count expires
// - two-speed after reset, powerup timer, wake
// - status bit one only on primary
// - monitor enabled by config, all external modes
// - no failure reports during start-up count
// - sample clock is lf oscillator over 64
// - latch set by fall, cleared by sample
// - failure switches internal, sets fail flag
// - interrupt only when fail enable set
// - never returns to failed clock automatically
// - after failure use current frequency select
// - reset or select toggle restarts, then clears
// - flag clears independently of fail condition
// - clock input and rc modes skip count
// - monitor enable forces two-speed on
// - frequency select code table
// - system clock select field decoding
// - glitch-free switch with hold low
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
module pcf_clock_control #(
  parameter int STARTUP_EDGES = pcf_pkg::STARTUP_EDGES,
  parameter int SAMPLE_DIVIDE = pcf_pkg::SAMPLE_DIVIDE
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire pcf_pkg::pcf_avs_req_t avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire pcf_pkg::pcf_config_t config_word_high_in,
  input wire logic ext_clk_in,
  input wire logic lf_osc_in,
  input wire logic [15:0] ext_ref_khz_in,
  input wire logic wake_in,
  input wire logic powerup_timer_done_in,
  output pcf_pkg::pcf_src_t sys_clk_src_out,
  output logic sys_clk_hold_out,
  output logic [15:0] sys_freq_khz_out,
  output logic pll_enable_out,
  output logic run_enable_out,
  output logic startup_status_flag_out,
  output logic failsafe_out,
  output logic osc_fail_irq_out,
  output logic primary_drive_on_out
);
  localparam logic [10:0] START_LAST = 11'(STARTUP_EDGES - 1);

  if (STARTUP_EDGES < 2 || STARTUP_EDGES > 2048) begin : g_chk_startup
    $error("STARTUP_EDGES must lie in 2 to 2048");
  end

  typedef struct packed {
    pcf_pkg::pcf_osc_control_t osc_control;
    logic [7:0] osc_control_second;
    pcf_pkg::pcf_osc_tuning_t osc_tuning;
    logic [7:0] int_priority;
    logic [7:0] int_enable;
    logic [7:0] int_flag;
    logic ack;
    logic [31:0] rdata;
    logic booted;
    logic ext_prev;
    logic start_run;
    logic [10:0] start_cnt;
    logic clear_armed;
    logic failsafe;
    logic fail_meta;
    logic fail_sync;
    pcf_pkg::pcf_src_t src;
    pcf_pkg::pcf_src_t sw_target;
    pcf_pkg::pcf_sw_state_t sw_state;
    logic [1:0] sw_cnt;
    logic hold;
    logic pll_on;
    logic [15:0] sys_khz;
    logic run;
    logic irq;
  } pcf_ctl_state_t;

  pcf_ctl_state_t state_reg;
  pcf_ctl_state_t state_next;

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic ext_fall;
  logic mon_active;
  logic sample_rise;
  logic sample_fall;
  logic fail_seen;
  logic bus_req;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rd;
  logic sel_hi_toggle;
  logic two_speed;
  logic start_go;
  logic new_ready;
  logic fail_event;
  logic hf_pll_ok;
  logic pll;
  logic [15:0] ref_khz;
  pcf_pkg::pcf_src_t target;

  // raw reset only releases through these two stages
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign ext_fall = state_reg.ext_prev & ~ext_clk_in;

  // monitor on for every external mode
  // no count in clock input or rc modes
  assign mon_active = config_word_high_in.fail_monitor_enable
    & pcf_pkg::is_external(config_word_high_in.primary_osc_select)
    & state_reg.booted & ~state_reg.start_run & ~state_reg.failsafe;

  pcf_sample_div #(
    .DIVIDE(SAMPLE_DIVIDE)
  ) u_sample_div (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_reg),
    .lf_osc_in(lf_osc_in),
    .sample_rise_out(sample_rise),
    .sample_fall_out(sample_fall)
  );

  pcf_fail_detect u_fail_detect (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_reg),
    .enable_in(mon_active),
    .ext_fall_in(ext_fall),
    .sample_rise_in(sample_rise),
    .sample_fall_in(sample_fall),
    .fail_out(fail_seen)
  );

  always_comb begin
    state_next = state_reg;
    state_next.ext_prev = ext_clk_in;
    state_next.booted = 1'b1;
    two_speed = config_word_high_in.two_speed_config_enable
      | config_word_high_in.fail_monitor_enable;

    // one wait cycle, then the answer
    bus_req = avs_req_in.read | avs_req_in.write;
    state_next.ack = bus_req & ~state_reg.ack;
    rd = 8'h00;
    case (avs_req_in.address)
      pcf_pkg::OFS_OSC_CONTROL: rd = state_reg.osc_control;
      pcf_pkg::OFS_OSC_CONTROL_SECOND: rd = state_reg.osc_control_second;
      pcf_pkg::OFS_OSC_TUNING: rd = state_reg.osc_tuning;
      pcf_pkg::OFS_INT_PRIORITY_TWO: rd = state_reg.int_priority;
      pcf_pkg::OFS_INT_ENABLE_TWO: rd = state_reg.int_enable;
      pcf_pkg::OFS_INT_FLAG_TWO: rd = state_reg.int_flag;
      pcf_pkg::OFS_CONFIG_WORD_HIGH: rd = config_word_high_in;
      default: rd = 8'h00;
    endcase
    if (bus_req && !state_reg.ack) begin
      state_next.rdata = {24'h000000, rd};
    end
    wr = avs_req_in.write & state_reg.ack & avs_req_in.byteenable[0];
    wdata = avs_req_in.writedata[7:0];
    sel_hi_toggle = 1'b0;
    if (wr) begin
      case (avs_req_in.address)
        pcf_pkg::OFS_OSC_CONTROL: begin
          sel_hi_toggle =
            wdata[1] != state_reg.osc_control.sys_clk_select[1];
          state_next.osc_control =
            (state_reg.osc_control & ~pcf_pkg::OSC_CONTROL_RW_MASK)
            | (wdata & pcf_pkg::OSC_CONTROL_RW_MASK);
        end
        pcf_pkg::OFS_OSC_CONTROL_SECOND: begin
          state_next.osc_control_second =
            wdata & pcf_pkg::SECOND_RW_MASK;
        end
        pcf_pkg::OFS_OSC_TUNING: begin
          state_next.osc_tuning = wdata;
        end
        pcf_pkg::OFS_INT_PRIORITY_TWO: begin
          state_next.int_priority = wdata & pcf_pkg::INT_TWO_RW_MASK;
        end
        pcf_pkg::OFS_INT_ENABLE_TWO: begin
          state_next.int_enable = wdata & pcf_pkg::INT_TWO_RW_MASK;
        end
        pcf_pkg::OFS_INT_FLAG_TWO: begin
          state_next.int_flag = wdata & pcf_pkg::INT_TWO_RW_MASK;
        end
        default: begin
        end
      endcase
    end

    // start after reset, powerup timer, wake
    start_go = ~state_reg.booted | wake_in | powerup_timer_done_in
      | sel_hi_toggle;
    if (~state_reg.booted | sel_hi_toggle) begin
      state_next.clear_armed = 1'b1;
    end
    if (start_go) begin
      if (pcf_pkg::needs_startup_count(
        config_word_high_in.primary_osc_select)) begin
        state_next.start_run = 1'b1;
        state_next.start_cnt = 11'h000;
      end else begin
        state_next.start_run = 1'b0;
        if (state_next.clear_armed) begin
          state_next.failsafe = 1'b0;
          state_next.clear_armed = 1'b0;
        end
      end
    end else if (state_reg.start_run && ext_fall) begin
      state_next.start_cnt = state_reg.start_cnt + 11'h001;
      if (state_reg.start_cnt == START_LAST) begin
        state_next.start_run = 1'b0;
        if (state_reg.clear_armed) begin
          state_next.failsafe = 1'b0;
          state_next.clear_armed = 1'b0;
        end
      end
    end

    state_next.fail_meta = fail_seen;
    state_next.fail_sync = state_reg.fail_meta;
    fail_event = state_reg.fail_sync & mon_active;
    // switch and flag; set beats a clear
    if (fail_event) begin
      state_next.failsafe = 1'b1;
      state_next.clear_armed = 1'b0;
      state_next.int_flag[pcf_pkg::OSC_FAIL_BIT] = 1'b1;
    end
    state_next.irq = state_next.int_flag[pcf_pkg::OSC_FAIL_BIT]
      & state_next.int_enable[pcf_pkg::OSC_FAIL_BIT];

    if (state_reg.failsafe || state_reg.osc_control.sys_clk_select[1])
    begin
      target = pcf_pkg::PCF_SRC_INTERNAL;
    end else if (state_reg.osc_control.sys_clk_select[0]) begin
      target = pcf_pkg::PCF_SRC_SECONDARY;
    end else if (state_next.start_run && two_speed) begin
      target = pcf_pkg::PCF_SRC_INTERNAL;
    end else begin
      target = pcf_pkg::PCF_SRC_PRIMARY;
    end
    // primary only ready after count
    // next count state, so a boot never starts an early switch
    new_ready = target != pcf_pkg::PCF_SRC_PRIMARY || !state_next.start_run;

    // two old edges, hold, two new
    case (state_reg.sw_state)
      pcf_pkg::PCF_SW_IDLE: begin
        if (target != state_reg.src && new_ready) begin
          state_next.sw_state = pcf_pkg::PCF_SW_WAIT_OLD;
          state_next.sw_target = target;
          state_next.sw_cnt = 2'h0;
        end
      end
      pcf_pkg::PCF_SW_WAIT_OLD: begin
        state_next.sw_cnt = state_reg.sw_cnt + 2'h1;
        if (state_reg.sw_cnt == pcf_pkg::SWITCH_OLD_LAST) begin
          state_next.sw_state = pcf_pkg::PCF_SW_HOLD;
          state_next.hold = 1'b1;
          state_next.sw_cnt = 2'h0;
        end
      end
      pcf_pkg::PCF_SW_HOLD: begin
        state_next.sw_cnt = state_reg.sw_cnt + 2'h1;
        if (state_reg.sw_cnt == pcf_pkg::SWITCH_NEW_LAST) begin
          state_next.sw_state = pcf_pkg::PCF_SW_IDLE;
          state_next.src = state_reg.sw_target;
          state_next.hold = 1'b0;
        end
      end
      default: begin
        state_next.sw_state = pcf_pkg::PCF_SW_IDLE;
        state_next.hold = 1'b0;
      end
    endcase

    // crystal without two-speed stalls code
    // held until primary is in, so no code runs before the count
    state_next.run = ~(pcf_pkg::needs_startup_count(
      config_word_high_in.primary_osc_select) && !two_speed
      && target == pcf_pkg::PCF_SRC_PRIMARY
      && (state_next.start_run
      || state_next.src != pcf_pkg::PCF_SRC_PRIMARY)) & ~state_next.hold;
    state_next.osc_control.startup_status_flag =
      state_next.src == pcf_pkg::PCF_SRC_PRIMARY;
    state_next.osc_control.hf_stable = 1'b1;

    // internal needs 8 or 16 MHz
    hf_pll_ok =
      state_reg.osc_control.int_osc_freq_select == pcf_pkg::FREQ_SEL_8MHZ
      || state_reg.osc_control.int_osc_freq_select == pcf_pkg::FREQ_SEL_16MHZ;
    ref_khz = pcf_pkg::int_freq_khz(
      state_reg.osc_control.int_osc_freq_select);
    pll = hf_pll_ok & (config_word_high_in.pll_config_enable
      | state_reg.osc_tuning.pll_soft_enable);
    case (state_reg.src)
      pcf_pkg::PCF_SRC_PRIMARY: begin
        if (pcf_pkg::is_external(config_word_high_in.primary_osc_select))
        begin
          ref_khz = ext_ref_khz_in;
          // reference from 4 to 16 MHz
          pll = config_word_high_in.pll_config_enable
            && ext_ref_khz_in >= pcf_pkg::PLL_MIN_KHZ
            && ext_ref_khz_in <= pcf_pkg::PLL_MAX_KHZ;
        end
      end
      pcf_pkg::PCF_SRC_SECONDARY: begin
        ref_khz = pcf_pkg::SECONDARY_KHZ;
        pll = 1'b0;
      end
      default: begin
      end
    endcase
    state_next.pll_on = pll;
    state_next.sys_khz = pll ? 16'(ref_khz * pcf_pkg::PLL_FACTOR)
      : ref_khz;
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= '0;
      state_reg.osc_control <= pcf_pkg::RST_OSC_CONTROL;
      state_reg.osc_control_second <= pcf_pkg::RST_OSC_CONTROL_SECOND;
      state_reg.osc_tuning <= pcf_pkg::RST_OSC_TUNING;
      state_reg.int_priority <= pcf_pkg::RST_INT_TWO;
      state_reg.int_enable <= pcf_pkg::RST_INT_TWO;
      state_reg.int_flag <= pcf_pkg::RST_INT_TWO;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_waitrequest_out = bus_req & ~state_reg.ack;
  assign avs_readdata_out = state_reg.rdata;
  assign sys_clk_src_out = state_reg.src;
  assign sys_clk_hold_out = state_reg.hold;
  assign sys_freq_khz_out = state_reg.sys_khz;
  assign pll_enable_out = state_reg.pll_on;
  assign run_enable_out = state_reg.run;
  assign startup_status_flag_out =
    state_reg.osc_control.startup_status_flag;
  assign failsafe_out = state_reg.failsafe;
  assign osc_fail_irq_out = state_reg.irq;
  assign primary_drive_on_out =
    state_reg.osc_control_second[pcf_pkg::PRI_DRIVE_BIT];
endmodule // pcf_clock_control

// file: hdl/pcf_pkg.sv
// constants and types of the clock start-up and fail-safe block
package pcf_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_OSC_CONTROL = 5'h00;
  localparam logic [4:0] OFS_OSC_CONTROL_SECOND = 5'h04;
  localparam logic [4:0] OFS_OSC_TUNING = 5'h08;
  localparam logic [4:0] OFS_INT_PRIORITY_TWO = 5'h0c;
  localparam logic [4:0] OFS_INT_ENABLE_TWO = 5'h10;
  localparam logic [4:0] OFS_INT_FLAG_TWO = 5'h14;
  localparam logic [4:0] OFS_CONFIG_WORD_HIGH = 5'h18;
  // values after reset
  localparam logic [7:0] RST_OSC_CONTROL = 8'h30;
  localparam logic [7:0] RST_OSC_CONTROL_SECOND = 8'h04;
  localparam logic [7:0] RST_OSC_TUNING = 8'h00;
  localparam logic [7:0] RST_INT_TWO = 8'h00;
  // field positions and writable masks
  localparam int OSC_FAIL_BIT = 7;
  localparam int PRI_DRIVE_BIT = 2;
  localparam logic [7:0] OSC_CONTROL_RW_MASK = 8'hf3;
  localparam logic [7:0] SECOND_RW_MASK = 8'h04;
  localparam logic [7:0] INT_TWO_RW_MASK = 8'hfa;
  // primary oscillator select codes; 8 and above are internal
  localparam logic [3:0] PRI_SEL_LOW_POWER = 4'h0;
  localparam logic [3:0] PRI_SEL_STANDARD = 4'h1;
  localparam logic [3:0] PRI_SEL_HIGH_SPEED = 4'h2;
  localparam logic [3:0] PRI_SEL_RES_CAP = 4'h3;
  localparam logic [3:0] PRI_SEL_CLOCK_IN = 4'h4;
  localparam logic [3:0] PRI_SEL_INTERNAL_MIN = 4'h8;
  // counts in edges
  localparam int STARTUP_EDGES = 1024;
  localparam int SAMPLE_DIVIDE = 64;
  localparam logic [1:0] SWITCH_OLD_LAST = 2'h1;
  localparam logic [1:0] SWITCH_NEW_LAST = 2'h1;
  // multiplier
  localparam logic [15:0] PLL_MIN_KHZ = 16'h0fa0;
  localparam logic [15:0] PLL_MAX_KHZ = 16'h3e80;
  localparam logic [15:0] PLL_FACTOR = 16'h0004;
  localparam logic [15:0] SECONDARY_KHZ = 16'h0020;
  localparam logic [2:0] FREQ_SEL_8MHZ = 3'h6;
  localparam logic [2:0] FREQ_SEL_16MHZ = 3'h7;

  typedef struct packed {
    logic two_speed_config_enable;
    logic fail_monitor_enable;
    logic pclken;
    logic pll_config_enable;
    logic [3:0] primary_osc_select;
  } pcf_config_t;

  typedef struct packed {
    logic idle_enable;
    logic [2:0] int_osc_freq_select;
    logic startup_status_flag;
    logic hf_stable;
    logic [1:0] sys_clk_select;
  } pcf_osc_control_t;

  typedef struct packed {
    logic int_src;
    logic pll_soft_enable;
    logic [5:0] tune;
  } pcf_osc_tuning_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pcf_avs_req_t;

  typedef enum logic [1:0] {
    PCF_SRC_INTERNAL,
    PCF_SRC_PRIMARY,
    PCF_SRC_SECONDARY
  } pcf_src_t;

  typedef enum logic [1:0] {
    PCF_SW_IDLE,
    PCF_SW_WAIT_OLD,
    PCF_SW_HOLD
  } pcf_sw_state_t;

  function automatic logic is_external(input logic [3:0] sel);
    return sel < PRI_SEL_INTERNAL_MIN;
  endfunction

  function automatic logic needs_startup_count(input logic [3:0] sel);
    return sel == PRI_SEL_LOW_POWER || sel == PRI_SEL_STANDARD
      || sel == PRI_SEL_HIGH_SPEED;
  endfunction

  function automatic logic [15:0] int_freq_khz(input logic [2:0] sel);
    case (sel)
      3'h7: return 16'h3e80;
      3'h6: return 16'h1f40;
      3'h5: return 16'h0fa0;
      3'h4: return 16'h07d0;
      3'h3: return 16'h03e8;
      3'h2: return 16'h01f4;
      3'h1: return 16'h00fa;
      default: return 16'h001f;
    endcase
  endfunction
endpackage

// file: hdl/pcf_sample_div.sv
// divides the low-frequency oscillator into the monitor sample clock
`timescale 1ns/1ps
module pcf_sample_div #(
  parameter int DIVIDE = pcf_pkg::SAMPLE_DIVIDE
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic lf_osc_in,
  output logic sample_rise_out,
  output logic sample_fall_out
);
  localparam logic [7:0] HALF_LAST = 8'(DIVIDE / 2 - 1);

  typedef struct packed {
    logic lf_prev;
    logic [7:0] cnt;
    logic sample;
    logic rise;
    logic fall;
  } pcf_div_state_t;

  pcf_div_state_t state_reg;
  pcf_div_state_t state_next;

  if (DIVIDE < 2 || DIVIDE > 512 || DIVIDE % 2 != 0) begin : g_chk
    $error("DIVIDE must be even, 2 to 512");
  end

  always_comb begin
    state_next = state_reg;
    state_next.lf_prev = lf_osc_in;
    state_next.rise = 1'b0;
    state_next.fall = 1'b0;
    if (lf_osc_in && !state_reg.lf_prev) begin
      state_next.cnt = state_reg.cnt + 8'h01;
      if (state_reg.cnt == HALF_LAST) begin
        state_next.cnt = 8'h00;
        state_next.sample = ~state_reg.sample;
        state_next.rise = ~state_reg.sample;
        state_next.fall = state_reg.sample;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sample_rise_out = state_reg.rise;
  assign sample_fall_out = state_reg.fall;
endmodule // pcf_sample_div

// file: hdl/pcf_fail_detect.sv
// latch-based detector of a stopped external clock
`timescale 1ns/1ps
module pcf_fail_detect (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic ext_fall_in,
  input wire logic sample_rise_in,
  input wire logic sample_fall_in,
  output logic fail_out
);
  typedef struct packed {
    logic seen;
    logic fail;
  } pcf_det_state_t;

  pcf_det_state_t state_reg;
  pcf_det_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // set on ext fall, clear on sample rise
    if (!enable_in) begin
      state_next = '0;
    end else begin
      if (sample_rise_in) begin
        state_next.seen = 1'b0;
      end
      // a fall in the same cycle wins, avoiding a false alarm
      if (ext_fall_in) begin
        state_next.seen = 1'b1;
      end
      if (sample_fall_in && !state_reg.seen && !ext_fall_in) begin
        state_next.fail = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fail_out = state_reg.fail;
endmodule // pcf_fail_detect

// file: verification/pcf_clock_control_sva.sv
// assertions on the ports of the clock control block
`timescale 1ns/1ps
module pcf_clock_control_sva (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire pcf_pkg::pcf_config_t config_word_high_in,
  input wire logic [15:0] ext_ref_khz_in,
  input wire pcf_pkg::pcf_src_t sys_clk_src_out,
  input wire logic sys_clk_hold_out,
  input wire logic [15:0] sys_freq_khz_out,
  input wire logic pll_enable_out,
  input wire logic run_enable_out,
  input wire logic failsafe_out
);
  logic [2:0] up_reg;
  logic prim;
  logic xtl;
  assign prim = sys_clk_src_out == pcf_pkg::PCF_SRC_PRIMARY;
  assign xtl =
    config_word_high_in.primary_osc_select < pcf_pkg::PRI_SEL_RES_CAP;
  // settle time after reset, switch-over may still run
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h7) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_pll_ext;
    (prim && !config_word_high_in.primary_osc_select[3]
      && $stable(ext_ref_khz_in) && $stable(config_word_high_in))[*3]
      |-> pll_enable_out == (config_word_high_in.pll_config_enable
      && ext_ref_khz_in >= 16'h0fa0 && ext_ref_khz_in <= 16'h3e80);
  endproperty
  a_pll_ext: assert property (p_pll_ext)
    else $error("multiplier enable wrong");
  property p_freq;
    (prim && pll_enable_out && !config_word_high_in.primary_osc_select[3]
      && $stable(ext_ref_khz_in))[*3]
      |-> sys_freq_khz_out == {ext_ref_khz_in[13:0], 2'h0};
  endproperty
  a_freq: assert property (p_freq)
    else $error("multiplied frequency wrong");
  property p_fail_sw;
    $rose(failsafe_out) |-> ##[0:12] !prim && !sys_clk_src_out[1];
  endproperty
  a_fail_sw: assert property (p_fail_sw)
    else $error("no switch to internal");
  property p_fail_stay;
    failsafe_out[*8] |-> sys_clk_src_out == pcf_pkg::PCF_SRC_INTERNAL;
  endproperty
  a_fail_stay: assert property (p_fail_stay)
    else $error("left internal during fail-safe");
  property p_no_run;
    !config_word_high_in.two_speed_config_enable
      && !config_word_high_in.fail_monitor_enable
      && xtl && !prim && up_reg == 3'h7 |-> !run_enable_out;
  endproperty
  a_no_run: assert property (p_no_run)
    else $error("ran during crystal start");
  property p_two_speed;
    (config_word_high_in.two_speed_config_enable
      || config_word_high_in.fail_monitor_enable)
      && !sys_clk_hold_out && !$past(sys_clk_hold_out) && up_reg == 3'h7
      |-> run_enable_out;
  endproperty
  a_two_speed: assert property (p_two_speed)
    else $error("halted with two-speed on");
  property p_hold;
    $rose(sys_clk_hold_out) |-> ##1 sys_clk_hold_out ##1 !sys_clk_hold_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold length wrong");
  property p_src_chg;
    $changed(sys_clk_src_out) |-> $fell(sys_clk_hold_out);
  endproperty
  a_src_chg: assert property (p_src_chg)
    else $error("source changed outside hold");
endmodule // pcf_clock_control_sva
bind pcf_clock_control pcf_clock_control_sva chk_u (.clk_in, .rst_n_in,
  .config_word_high_in, .ext_ref_khz_in, .sys_clk_src_out, .sys_clk_hold_out,
  .sys_freq_khz_out, .pll_enable_out, .run_enable_out, .failsafe_out);

// file: verification/pcf_ext_osc.sv
// external oscillator model that can be stopped
`timescale 1ns/1ps
module pcf_ext_osc (
  input wire logic clk_in,
  input wire logic run_in,
  output logic ext_clk_out
);
  initial ext_clk_out = 1'b1;
  // a dead crystal parks high, giving no falling edges
  always @(posedge clk_in) begin
    ext_clk_out <= run_in ? !ext_clk_out : 1'b1;
  end
endmodule // pcf_ext_osc

// file: verification/pcf_clock_control_test.sv
// self-checking bench of the clock control block
`timescale 1ns/1ps
module pcf_clock_control_test;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  pcf_pkg::pcf_avs_req_t req = '0;
  pcf_pkg::pcf_config_t cfg = 8'h04;
  logic [15:0] ref_khz = 16'h1f40;
  logic wake = 1'b0;
  logic pwr = 1'b0;
  logic osc_run = 1'b1;
  logic [2:0] lf_cnt = 3'h0;
  logic ext_clk;
  logic [31:0] rdata;
  logic waitreq;
  pcf_pkg::pcf_src_t src;
  logic [15:0] freq;
  logic pll_on;
  logic run;
  logic status;
  logic fsafe;
  logic irq;
  logic drive;
  logic [7:0] q;
  int n_errors = 0;
  int num_checks = 0;
  logic [13:0] rows [0:19] = '{{1'b0, 5'h00, 8'h3c}, {1'b0, 5'h04, 8'h04},
    {1'b0, 5'h08, 8'h00}, {1'b0, 5'h0c, 8'h00}, {1'b0, 5'h10, 8'h00},
    {1'b0, 5'h14, 8'h00}, {1'b0, 5'h18, 8'h04}, {1'b0, 5'h1c, 8'h00},
    {1'b1, 5'h0c, 8'hff}, {1'b0, 5'h0c, 8'hfa}, {1'b1, 5'h18, 8'h00},
    {1'b0, 5'h18, 8'h04}, {1'b1, 5'h1c, 8'hff}, {1'b0, 5'h1c, 8'h00},
    {1'b1, 5'h04, 8'h00}, {1'b0, 5'h04, 8'h00}, {1'b1, 5'h04, 8'hff},
    {1'b0, 5'h04, 8'h04}, {1'b1, 5'h08, 8'h40}, {1'b0, 5'h08, 8'h40}};
  logic [33:0] plls [0:4] = '{{1'b1, 16'h0fa0, 1'b1, 16'h3e80},
    {1'b1, 16'h0f9f, 1'b0, 16'h0f9f}, {1'b1, 16'h3e80, 1'b1, 16'hfa00},
    {1'b1, 16'h3e81, 1'b0, 16'h3e81}, {1'b0, 16'h1f40, 1'b0, 16'h1f40}};
  logic [24:0] ints [0:3] = '{{8'h72, 1'b1, 16'hfa00},
    {8'h62, 1'b1, 16'h7d00}, {8'h52, 1'b0, 16'h0fa0},
    {8'h02, 1'b0, 16'h001f}};
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) lf_cnt <= lf_cnt + 3'h1;
  pcf_clock_control #(.STARTUP_EDGES(8), .SAMPLE_DIVIDE(4)) dut_u (
    .clk_in, .rst_n_in, .avs_req_in(req), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .config_word_high_in(cfg),
    .ext_clk_in(ext_clk), .lf_osc_in(lf_cnt[2]), .ext_ref_khz_in(ref_khz),
    .wake_in(wake), .powerup_timer_done_in(pwr), .sys_clk_src_out(src),
    .sys_clk_hold_out(), .sys_freq_khz_out(freq), .pll_enable_out(pll_on),
    .run_enable_out(run), .startup_status_flag_out(status),
    .failsafe_out(fsafe), .osc_fail_irq_out(irq),
    .primary_drive_on_out(drive));
  pcf_ext_osc osc_u (.clk_in, .run_in(osc_run), .ext_clk_out(ext_clk));
  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req.write <= wr;
    req.read <= !wr;
    req.address <= a;
    req.writedata <= {24'h0, d};
    req.byteenable <= 4'hf;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    // three idle edges so no strobe is assigned twice in one step
    repeat (3) @(posedge clk_in);
    if (n >= 20) begin
      n_errors++;
      print_verdict();
    end
  endtask
  function automatic logic probe(input int k);
    case (k)
      0: return status;
      1: return fsafe;
      2: return src == pcf_pkg::PCF_SRC_INTERNAL;
      default: return src == pcf_pkg::PCF_SRC_PRIMARY;
    endcase
  endfunction
  task automatic wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (probe(k) !== v && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 400) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic restart(input logic [7:0] c);
    rst_n_in <= 1'b0;
    cfg <= c;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
  initial begin
    restart(8'h04);
    wait_for(3, 1'b1);
    foreach (rows[i]) begin
      bus(rows[i][13], rows[i][12:8], rows[i][7:0]);
      if (!rows[i][13]) begin
        chk(q, rows[i][7:0]);
      end
    end
    chk(drive, 1'b1);
    bus(1'b1, 5'h04, 8'h00);
    chk(drive, 1'b0);
    foreach (plls[i]) begin
      cfg.pll_config_enable <= plls[i][33];
      ref_khz <= plls[i][32:17];
      repeat (3) @(posedge clk_in);
      chk(pll_on, plls[i][16]);
      chk(freq, plls[i][15:0]);
    end
    foreach (ints[i]) begin
      bus(1'b1, 5'h00, ints[i][24:17]);
      wait_for(2, 1'b1);
      repeat (3) @(posedge clk_in);
      chk(pll_on, ints[i][16]);
      chk(freq, ints[i][15:0]);
    end
    // crystal without two-speed: execution waits for the count
    restart(8'h01);
    chk(run, 1'b0);
    wait_for(0, 1'b1);
    restart(8'h81);
    chk(run, 1'b1);
    wait_for(0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      osc_run <= 1'b0;
      wake <= i == 0;
      pwr <= i == 1;
      @(posedge clk_in);
      wake <= 1'b0;
      pwr <= 1'b0;
      wait_for(0, 1'b0);
      chk(run, 1'b1);
      osc_run <= 1'b1;
      wait_for(0, 1'b1);
    end
    // stopped crystal at reset must not look like a failure
    osc_run <= 1'b0;
    restart(8'h41);
    repeat (60) @(posedge clk_in);
    chk(fsafe, 1'b0);
    chk(run, 1'b1);
    osc_run <= 1'b1;
    wait_for(0, 1'b1);
    bus(1'b1, 5'h00, 8'h70);
    osc_run <= 1'b0;
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    chk(status, 1'b0);
    // frequency is registered one cycle after the source
    @(posedge clk_in);
    chk(freq, 16'h3e80);
    bus(1'b0, 5'h14, 8'h00);
    chk(q, 8'h80);
    chk(irq, 1'b0);
    bus(1'b1, 5'h10, 8'h80);
    chk(irq, 1'b1);
    bus(1'b1, 5'h14, 8'h00);
    chk(irq, 1'b0);
    chk(fsafe, 1'b1);
    osc_run <= 1'b1;
    repeat (40) @(posedge clk_in);
    chk(probe(2), 1'b1);
    bus(1'b1, 5'h00, 8'h72);
    bus(1'b1, 5'h00, 8'h70);
    wait_for(1, 1'b0);
    wait_for(3, 1'b1);
    bus(1'b0, 5'h00, 8'h00);
    chk(q[3], 1'b1);
    print_verdict();
  end
endmodule // pcf_clock_control_test
